// >>> hdl/gpfg_top.sv
// Port F and port G general-purpose I/O with timer and analog takeover
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Eight read/write latches per port
// - Reset leaves data latches unchanged
// - Port F direction one drives latch
// - Port G direction zero leaves high impedance
// - Reset clears port F direction
// - Reset clears port G direction
// - Port F read: latch or pin
// - Port G read: latch or pin
// - Data writes always update latches
// - Input pin write changes latch only
// - Upper port F pins follow timer select
// - Selected analog channel overrides port G pin
// - Unselected port G pins stay digital
module gpfg_top
	import gpfg_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Register port
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Port F pins
	input wire logic [7:0] port_f_pin_in,
	output logic [7:0] port_f_pin_out,
	output logic [7:0] port_f_pin_oe_n_out,
	// Timer channels on port F bits 7..4
	input wire logic [7:0] edge_level_select_field_in,
	input wire logic [3:0] timer_b_channel_out_in,
	input wire logic [3:0] timer_b_channel_oe_in,
	output logic [3:0] timer_b_channel_pins_out,
	// Port G pins and analog select
	input wire logic [7:0] port_g_pin_in,
	output logic [7:0] port_g_pin_out,
	output logic [7:0] port_g_pin_oe_n_out,
	input wire logic adc_enable_in,
	input wire logic [2:0] adc_channel_in
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] port_f_latch_q, port_f_latch_d;
	logic [7:0] port_g_latch_q, port_g_latch_d;
	logic [7:0] port_f_dir_q, port_f_dir_d;
	logic [7:0] port_g_dir_q, port_g_dir_d;
	logic [7:0] rdata_q, rdata_d;
	gpfg_pins_type pf_q, pf_d;
	gpfg_pins_type pg_q, pg_d;
	logic [3:0] tmr_in_q, tmr_in_d;
	gpfg_bus_type bus;

	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire sel_fl = bus.addr == GPFG_ADDR_F_LATCH;
	wire sel_gl = bus.addr == GPFG_ADDR_G_LATCH;
	wire sel_fd = bus.addr == GPFG_ADDR_F_DIR;
	wire sel_gd = bus.addr == GPFG_ADDR_G_DIR;

	assign port_f_latch_d = (bus.wr && sel_fl) ? bus.wdata : port_f_latch_q;
	assign port_g_latch_d = (bus.wr && sel_gl) ? bus.wdata : port_g_latch_q;
	assign port_f_dir_d = (bus.wr && sel_fd) ? bus.wdata : port_f_dir_q;
	assign port_g_dir_d = (bus.wr && sel_gd) ? bus.wdata : port_g_dir_q;

	// ------------------------------------------------------------
	// Pin ownership
	// ------------------------------------------------------------
	logic [7:0] tmr_own;
	logic [7:0] tmr_o;
	logic [7:0] tmr_oe;
	genvar gi;
	generate
		for (gi = 0; gi < GPFG_TMR_N; gi++) begin : g_tmr
			// Nonzero select gives pin to timer
			assign tmr_own[GPFG_TMR_LO + gi] =
				edge_level_select_field_in[2 * gi +: 2] != GPFG_ELS_GPIO;
			assign tmr_o[GPFG_TMR_LO + gi] = timer_b_channel_out_in[gi];
			assign tmr_oe[GPFG_TMR_LO + gi] = timer_b_channel_oe_in[gi];
		end
	endgenerate
	assign tmr_own[GPFG_TMR_LO - 1:0] = '0;
	assign tmr_o[GPFG_TMR_LO - 1:0] = '0;
	assign tmr_oe[GPFG_TMR_LO - 1:0] = '0;

	wire [7:0] adc_own = adc_enable_in ? (8'h01 << adc_channel_in) : 8'h00;

	// Port F drive from latch or timer
	wire [7:0] f_oe = (port_f_dir_q & ~tmr_own) | (tmr_own & tmr_oe);
	wire [7:0] f_o = (port_f_latch_q & ~tmr_own) | (tmr_o & tmr_own);
	assign pf_d = '{o: f_o, oe_n: ~f_oe};

	wire [7:0] g_oe = port_g_dir_q & ~adc_own;
	assign pg_d = '{o: port_g_latch_q & g_oe, oe_n: ~g_oe};

	assign tmr_in_d = port_f_pin_in[7:4];

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Port F latch or pin
	wire [7:0] f_rd = (port_f_dir_q & port_f_latch_q) | (~port_f_dir_q & port_f_pin_in);
	// Port G latch or pin; analog pins read zero to spare the input stage
	wire [7:0] g_rd = ((port_g_dir_q & port_g_latch_q) | (~port_g_dir_q & port_g_pin_in))
		& ~adc_own;
	wire [7:0] rd_mux = sel_fl ? f_rd :
		sel_gl ? g_rd :
		sel_fd ? port_f_dir_q :
		sel_gd ? port_g_dir_q : GPFG_RD_NONE;
	assign rdata_d = bus.rd ? rd_mux : GPFG_RD_NONE;

	// ------------------------------------------------------------
	// Flip-flops
	// ------------------------------------------------------------
	// Data latches have no reset
	always_ff @(posedge clock_in) begin
		port_f_latch_q <= port_f_latch_d;
		port_g_latch_q <= port_g_latch_d;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			port_f_dir_q <= GPFG_DIR_RST;
			port_g_dir_q <= GPFG_DIR_RST;
		end else begin
			port_f_dir_q <= port_f_dir_d;
			port_g_dir_q <= port_g_dir_d;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_q <= GPFG_RD_NONE;
			pf_q <= '{o: 8'h00, oe_n: 8'hFF};
			pg_q <= '{o: 8'h00, oe_n: 8'hFF};
			tmr_in_q <= 4'h0;
		end else begin
			rdata_q <= rdata_d;
			pf_q <= pf_d;
			pg_q <= pg_d;
			tmr_in_q <= tmr_in_d;
		end
	end

	assign rdata_out = rdata_q;
	assign port_f_pin_out = pf_q.o;
	assign port_f_pin_oe_n_out = pf_q.oe_n;
	assign port_g_pin_out = pg_q.o;
	assign port_g_pin_oe_n_out = pg_q.oe_n;
	assign timer_b_channel_pins_out = tmr_in_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_f_dir_reset;
		@(posedge clock_in) rst_in |=> port_f_dir_q == GPFG_DIR_RST;
	endproperty
	a_f_dir_reset: assert property (p_f_dir_reset) else $error("port F dir not cleared");

	property p_g_dir_reset;
		@(posedge clock_in) rst_in |=> port_g_dir_q == GPFG_DIR_RST;
	endproperty
	a_g_dir_reset: assert property (p_g_dir_reset) else $error("port G dir not cleared");

	// Write history: a latch never written holds no value to keep
	logic f_seen_q;
	logic g_seen_q;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			f_seen_q <= 1'h0;
			g_seen_q <= 1'h0;
		end else begin
			if (wr_in && sel_fl) begin
				f_seen_q <= 1'h1;
			end
			if (wr_in && sel_gl) begin
				g_seen_q <= 1'h1;
			end
		end
	end

	property p_latch_keep;
		@(posedge clock_in) (rst_in && !wr_in && f_seen_q) |=> $stable(port_f_latch_q);
	endproperty
	a_latch_keep: assert property (p_latch_keep) else $error("reset touched latch");

	property p_g_latch_keep;
		@(posedge clock_in) (rst_in && !wr_in && g_seen_q) |=> $stable(port_g_latch_q);
	endproperty
	a_g_latch_keep: assert property (p_g_latch_keep) else $error("reset touched G latch");

	property p_latch_write;
		@(posedge clock_in) (wr_in && addr_in == GPFG_ADDR_F_LATCH)
			|=> port_f_latch_q == $past(wdata_in);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");

	property p_f_read;
		@(posedge clock_in) disable iff (rst_in) (rd_in && addr_in == GPFG_ADDR_F_LATCH)
			|=> rdata_out == (($past(port_f_dir_q) & $past(port_f_latch_q))
			| (~$past(port_f_dir_q) & $past(port_f_pin_in)));
	endproperty
	a_f_read: assert property (p_f_read) else $error("port F read wrong");

	property p_g_read_in;
		@(posedge clock_in) disable iff (rst_in)
			(rd_in && addr_in == GPFG_ADDR_G_LATCH && port_g_dir_q == 8'h00 && !adc_enable_in)
			|=> rdata_out == $past(port_g_pin_in);
	endproperty
	a_g_read_in: assert property (p_g_read_in) else $error("port G input read wrong");

	property p_f_drive;
		@(posedge clock_in) disable iff (rst_in)
			(edge_level_select_field_in == 8'h00)
			|=> port_f_pin_oe_n_out == ~$past(port_f_dir_q) && port_f_pin_out == $past(port_f_latch_q);
	endproperty
	a_f_drive: assert property (p_f_drive) else $error("port F drive wrong");

	property p_adc_float;
		@(posedge clock_in) disable iff (rst_in)
			adc_enable_in |=> port_g_pin_oe_n_out[$past(adc_channel_in)];
	endproperty
	a_adc_float: assert property (p_adc_float) else $error("analog pin driven");

	property p_g_digital;
		@(posedge clock_in) disable iff (rst_in)
			!adc_enable_in |=> port_g_pin_oe_n_out == ~$past(port_g_dir_q);
	endproperty
	a_g_digital: assert property (p_g_digital) else $error("port G digital drive wrong");

	property p_g_write;
		@(posedge clock_in) (wr_in && addr_in == GPFG_ADDR_G_LATCH)
			|=> port_g_latch_q == $past(wdata_in);
	endproperty
	a_g_write: assert property (p_g_write) else $error("G latch write lost");

	property p_f_dir_write;
		@(posedge clock_in) disable iff (rst_in) (wr_in && addr_in == GPFG_ADDR_F_DIR)
			|=> port_f_dir_q == $past(wdata_in);
	endproperty
	a_f_dir_write: assert property (p_f_dir_write) else $error("F dir write lost");

	property p_g_dir_write;
		@(posedge clock_in) disable iff (rst_in) (wr_in && addr_in == GPFG_ADDR_G_DIR)
			|=> port_g_dir_q == $past(wdata_in);
	endproperty
	a_g_dir_write: assert property (p_g_dir_write) else $error("G dir write lost");

	property p_g_drive;
		@(posedge clock_in) disable iff (rst_in)
			!adc_enable_in |=> port_g_pin_out == ($past(port_g_latch_q) & $past(port_g_dir_q));
	endproperty
	a_g_drive: assert property (p_g_drive) else $error("port G drive value wrong");

	property p_tmr_drive;
		@(posedge clock_in) disable iff (rst_in)
			1'h1 |=> (port_f_pin_oe_n_out & $past(tmr_own)) == (~$past(tmr_oe) & $past(tmr_own));
	endproperty
	a_tmr_drive: assert property (p_tmr_drive) else $error("timer pin drive wrong");

	property p_tmr_sample;
		@(posedge clock_in) disable iff (rst_in)
			1'h1 |=> timer_b_channel_pins_out == $past(port_f_pin_in[7:4]);
	endproperty
	a_tmr_sample: assert property (p_tmr_sample) else $error("timer pin sample wrong");

	property p_g_read;
		@(posedge clock_in) disable iff (rst_in)
			(rd_in && addr_in == GPFG_ADDR_G_LATCH && !adc_enable_in)
			|=> rdata_out == (($past(port_g_dir_q) & $past(port_g_latch_q))
			| (~$past(port_g_dir_q) & $past(port_g_pin_in)));
	endproperty
	a_g_read: assert property (p_g_read) else $error("port G read wrong");

	property p_input_write;
		@(posedge clock_in) disable iff (rst_in)
			(wr_in && addr_in == GPFG_ADDR_F_LATCH && port_f_dir_q == 8'h00
			&& edge_level_select_field_in == 8'h00) |=> port_f_pin_oe_n_out == 8'hFF;
	endproperty
	a_input_write: assert property (p_input_write) else $error("input pin driven");

	property p_adc_read;
		@(posedge clock_in) disable iff (rst_in)
			(rd_in && addr_in == GPFG_ADDR_G_LATCH && adc_enable_in)
			|=> !rdata_out[$past(adc_channel_in)];
	endproperty
	a_adc_read: assert property (p_adc_read) else $error("analog pin read nonzero");

	property p_rdata_idle;
		@(posedge clock_in) disable iff (rst_in)
			!rd_in |=> rdata_out == GPFG_RD_NONE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

	c_f_out: cover property (@(posedge clock_in) port_f_pin_oe_n_out != 8'hFF);
	c_g_read: cover property (@(posedge clock_in) rd_in && addr_in == GPFG_ADDR_G_LATCH);
	c_tmr: cover property (@(posedge clock_in) edge_level_select_field_in != 8'h00);
	c_adc: cover property (@(posedge clock_in) adc_enable_in && port_g_dir_q != 8'h00);
endmodule
`default_nettype wire

// >>> hdl/gpfg_pkg.sv
// Package for the port F and port G general-purpose I/O block
package gpfg_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] GPFG_ADDR_F_LATCH = 16'h0440;
	localparam logic [15:0] GPFG_ADDR_G_LATCH = 16'h0441;
	localparam logic [15:0] GPFG_ADDR_F_DIR = 16'h0444;
	localparam logic [15:0] GPFG_ADDR_G_DIR = 16'h0445;
	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int GPFG_W = 8;
	localparam logic [7:0] GPFG_DIR_RST = 8'h00;
	localparam logic [7:0] GPFG_RD_NONE = 8'h00;
	localparam logic [1:0] GPFG_ELS_GPIO = 2'h0;
	// Timer pins occupy port F bits 7..4
	localparam int GPFG_TMR_LO = 4;
	localparam int GPFG_TMR_N = 4;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gpfg_bus_type;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe_n;
	} gpfg_pins_type;
endpackage

// >>> testbench/gpfg_pin_model.sv
// Pin wires of ports F and G with external drivers
`timescale 1ns/1ps
`default_nettype none
module gpfg_pin_model (
	// Block side
	input wire logic [7:0] f_out_in,
	input wire logic [7:0] f_oe_n_in,
	input wire logic [7:0] g_out_in,
	input wire logic [7:0] g_oe_n_in,
	// Outside world levels
	input wire logic [7:0] ext_f_in,
	input wire logic [7:0] ext_g_in,
	// Resolved wires
	output logic [7:0] f_wire_out,
	output logic [7:0] g_wire_out
);
	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// Buffer on drives wire
	assign f_wire_out = (f_out_in & ~f_oe_n_in) | (ext_f_in & f_oe_n_in);
	assign g_wire_out = (g_out_in & ~g_oe_n_in) | (ext_g_in & g_oe_n_in);
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the port F and port G block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gpfg_pkg::*;
	logic clock_in = 0, rst_in = 1, wr = 0, rd = 0, adce = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00, els = 8'h00, extf = 8'h00, extg = 8'h00, rdata;
	logic [7:0] pfo, pfoe, pgo, pgoe, pfi, pgi, lf, lg, df, dg, v;
	logic [3:0] tout = 4'h0, toe = 4'h0, tpins;
	logic [2:0] adcc = 3'h0;
	int miscompares = 0, samples_checked = 0;
	gpfg_top gpfg_top_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .port_f_pin_in(pfi),
		.port_f_pin_out(pfo), .port_f_pin_oe_n_out(pfoe),
		.edge_level_select_field_in(els), .timer_b_channel_out_in(tout),
		.timer_b_channel_oe_in(toe), .timer_b_channel_pins_out(tpins),
		.port_g_pin_in(pgi), .port_g_pin_out(pgo), .port_g_pin_oe_n_out(pgoe),
		.adc_enable_in(adce), .adc_channel_in(adcc));
	gpfg_pin_model gpfg_pin_model_inst (.f_out_in(pfo), .f_oe_n_in(pfoe), .g_out_in(pgo),
		.g_oe_n_in(pgoe), .ext_f_in(extf), .ext_g_in(extg), .f_wire_out(pfi),
		.g_wire_out(pgi));
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bw(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_in);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clock_in);
		wr <= 0;
	endtask
	task automatic br(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock_in);
		rd <= 1;
		addr <= a;
		@(posedge clock_in);
		rd <= 0;
		#1 d = rdata;
	endtask
	function automatic logic [7:0] mix(input logic [7:0] dir, l, p);
		return (dir & l) | (~dir & p);
	endfunction
	task automatic test_done;
		if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000 miscompares++;
		test_done;
	end
	initial begin
		void'($urandom(74));
		repeat (12) @(posedge clock_in);
		rst_in <= 0;
		br(GPFG_ADDR_F_DIR, v); chk8("f_dir", GPFG_DIR_RST, v);
		br(GPFG_ADDR_G_DIR, v); chk8("g_dir", GPFG_DIR_RST, v);
		chk8("f_oe_n", 8'hFF, pfoe);
		chk8("g_oe_n", 8'hFF, pgoe);
		br(16'h0442, v); chk8("unmapped", GPFG_RD_NONE, v);
		for (int i = 0; i < 24; i++) begin
			{lf, lg, df, dg} = $urandom;
			{extf, extg} <= $urandom;
			bw(GPFG_ADDR_F_LATCH, lf);
			bw(GPFG_ADDR_G_LATCH, lg);
			bw(GPFG_ADDR_F_DIR, df);
			bw(GPFG_ADDR_G_DIR, dg);
			br(GPFG_ADDR_F_LATCH, v); chk8("f_read", mix(df, lf, extf), v);
			br(GPFG_ADDR_G_LATCH, v); chk8("g_read", mix(dg, lg, extg), v);
			chk8("f_oe_n", ~df, pfoe);
			chk8("g_oe_n", ~dg, pgoe);
			chk8("f_drive", lf & df, pfo & df);
			chk8("g_drive", lg & dg, pgo & dg);
		end
		// Latches survive a reset in mid-run
		bw(GPFG_ADDR_F_LATCH, 8'hA5);
		bw(GPFG_ADDR_G_LATCH, 8'h3C);
		@(posedge clock_in) rst_in <= 1;
		@(posedge clock_in) rst_in <= 0;
		br(GPFG_ADDR_G_DIR, v); chk8("g_dir", GPFG_DIR_RST, v);
		bw(GPFG_ADDR_F_DIR, 8'hFF);
		bw(GPFG_ADDR_G_DIR, 8'hFF);
		br(GPFG_ADDR_F_LATCH, v); chk8("f_kept", 8'hA5, v);
		br(GPFG_ADDR_G_LATCH, v); chk8("g_kept", 8'h3C, v);
		// Analog channel takes one G pin
		@(posedge clock_in);
		adce <= 1;
		adcc <= 3'h3;
		repeat (2) @(posedge clock_in);
		#1 chk8("g_oe_n_adc", 8'h08, pgoe);
		br(GPFG_ADDR_G_LATCH, v); chk8("g_read_adc", 8'h34, v);
		@(posedge clock_in);
		adce <= 0;
		// Timer owns pin F5
		bw(GPFG_ADDR_F_DIR, 8'h00);
		@(posedge clock_in);
		els <= 8'h04;
		toe <= 4'h2;
		tout <= 4'h2;
		repeat (3) @(posedge clock_in);
		#1 chk8("f_oe_n_tmr", 8'hDF, pfoe);
		chk8("f5_drive", 8'h20, pfo & 8'h20);
		chk8("tmr_pins", {4'h0, (extf[7:4] & 4'hD) | 4'h2}, {4'h0, tpins});
		test_done;
	end
endmodule
`default_nettype wire
